// ===== design/ram_power_pkg.sv
// What this block does
// - nine identical RAM power groups 0..8, control register of group n at 0x900 + n*0x10.
// - writing the set register (0x904 + n*0x10) turns on each section/retention bit written 1.
// - writing the clear register (0x908 + n*0x10) turns off each section/retention bit written 1.
// - reading the set or clear register returns the group's control value, with no side effect.
//
// Purpose : constants for the RAM section power register bank
// Assumes : AXI4-Lite, 32-bit data, 12-bit byte address
// Notes   : printed offsets are multiples of four, so they are byte addresses
package ram_power_pkg;
	localparam int          GROUP_COUNT       = 9;
	localparam int          ADDR_W            = 12;
	localparam logic [11:0] CTRL_BASE         = 12'h900;
	localparam logic [11:0] SET_BASE          = 12'h904;
	localparam logic [11:0] CLR_BASE          = 12'h908;
	localparam logic [11:0] GROUP_STRIDE      = 12'h010;
	localparam logic [11:0] SUPPLY_STAT_OFF   = 12'h640;
	localparam int          SECTION_LSB       = 0;
	localparam int          RETENTION_LSB     = 16;
	localparam logic [31:0] POWER_RESET       = 32'h0000ffff;
	localparam logic [31:0] SUPPLY_STAT_VALUE = 32'h00000000;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;
	typedef enum logic [1:0] {
		ACC_CTRL,
		ACC_SET,
		ACC_CLR,
		ACC_NONE
	} access_t;
endpackage : ram_power_pkg

// ===== design/ram_power_group.sv
// Purpose : one RAM block's power/retention control word
// Assumes : write strobes already decoded to this group
// Notes   : set and clear are one-cycle pulses, never both at once
`timescale 1ns/1ps
module ram_power_group
	import ram_power_pkg::*;
(
	input  wire  logic        clk,
	input  wire  logic        reset,
	input  wire  logic        wrCtrl,
	input  wire  logic        wrSet,
	input  wire  logic        wrClr,
	input  wire  logic [31:0] wrData,
	output logic       [31:0] power
);
	logic [31:0] power_r;
	logic [31:0] power_nxt;

	always_comb begin
		power_nxt = power_r;
		if (wrCtrl) begin
			power_nxt = wrData;
		end else if (wrSet) begin
			power_nxt = power_r | wrData;
		end else if (wrClr) begin
			power_nxt = power_r & ~wrData;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			power_r <= POWER_RESET;
		end else begin
			power_r <= power_nxt;
		end
	end

	assign power = power_r;

	AST_SET_NO_CLEAR: assert property (@(posedge clk) disable iff (reset)
		wrSet |=> ((power_r & $past(wrData)) == $past(wrData)))
		else $error("set bit did not turn on");
	AST_SET_KEEPS: assert property (@(posedge clk) disable iff (reset)
		wrSet |=> ((power_r & ~$past(wrData)) == ($past(power_r) & ~$past(wrData))))
		else $error("set changed an unwritten bit");
	AST_CLR_OFF: assert property (@(posedge clk) disable iff (reset)
		wrClr |=> ((power_r & $past(wrData)) == 32'h00000000))
		else $error("clear bit did not turn off");
	AST_CLR_KEEPS: assert property (@(posedge clk) disable iff (reset)
		wrClr |=> ((power_r | $past(wrData)) == ($past(power_r) | $past(wrData))))
		else $error("clear changed an unwritten bit");
	AST_HOLD: assert property (@(posedge clk) disable iff (reset)
		!(wrCtrl || wrSet || wrClr) |=> $stable(power_r))
		else $error("power word changed without a write");
endmodule : ram_power_group

// ===== design/axil_slave.sv
// Purpose : AXI4-Lite slave front end, one write and one read at a time
// Assumes : single clock, address and data may arrive in either order
// Notes   : write pulse lasts one cycle; read data sampled from rdValue
`timescale 1ns/1ps
module axil_slave
	import ram_power_pkg::*;
(
	input  wire  logic              clk,
	input  wire  logic              reset,
	input  wire  logic [ADDR_W-1:0] awaddr,
	input  wire  logic              awvalid,
	output logic                    awready,
	input  wire  logic [31:0]       wdata,
	input  wire  logic [3:0]        wstrb,
	input  wire  logic              wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire  logic              bready,
	input  wire  logic [ADDR_W-1:0] araddr,
	input  wire  logic              arvalid,
	output logic                    arready,
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire  logic              rready,
	output logic                    wrPulse,
	output logic [ADDR_W-1:0]       wrAddr,
	output logic [31:0]             wrData,
	input  wire  logic              wrOk,
	output logic [ADDR_W-1:0]       rdAddr,
	input  wire  logic [31:0]       rdValue,
	input  wire  logic              rdOk
);
	logic              awHave_r, awHave_nxt, wHave_r, wHave_nxt;
	logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
	logic [31:0]       wData_r, wData_nxt, rdata_r, rdata_nxt;
	logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [31:0]       strobeMask;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			strobeMask[8*b +: 8] = {8{wstrb[b]}};
		end
	end

	assign awready = !awHave_r && !bvalid_r;
	assign wready  = !wHave_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign wrPulse = awHave_r && wHave_r && !bvalid_r;
	assign wrAddr  = awAddr_r;
	assign wrData  = wData_r;
	assign rdAddr  = araddr;

	always_comb begin
		awHave_nxt = awHave_r;
		wHave_nxt  = wHave_r;
		awAddr_nxt = awAddr_r;
		wData_nxt  = wData_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt  = rresp_r;
		rdata_nxt  = rdata_r;
		if (awvalid && awready) begin
			awHave_nxt = 1'b1;
			awAddr_nxt = awaddr;
		end
		// unwritten byte lanes read as zero so set and clear writes leave them alone; a control write loads them as zero
		if (wvalid && wready) begin
			wHave_nxt = 1'b1;
			wData_nxt = wdata & strobeMask;
		end
		if (wrPulse) begin
			awHave_nxt = 1'b0;
			wHave_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = wrOk ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rdOk ? rdValue : 32'h00000000;
			rresp_nxt  = rdOk ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			awHave_r <= 1'b0;
			wHave_r  <= 1'b0;
			awAddr_r <= '0;
			wData_r  <= 32'h00000000;
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= 32'h00000000;
		end else begin
			awHave_r <= awHave_nxt;
			wHave_r  <= wHave_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r  <= wData_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r  <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r  <= rresp_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign bvalid = bvalid_r;
	assign bresp  = bresp_r;
	assign rvalid = rvalid_r;
	assign rresp  = rresp_r;
	assign rdata  = rdata_r;

	AST_B_AFTER_WRITE: assert property (@(posedge clk) disable iff (reset)
		wrPulse |=> bvalid)
		else $error("write response missing");
	AST_R_HOLDS: assert property (@(posedge clk) disable iff (reset)
		(rvalid && !rready) |=> (rvalid && $stable(rdata)))
		else $error("read data dropped before taken");
endmodule : axil_slave

// ===== design/ram_section_power_control.sv
// Purpose : RAM section power and retention control bank, nine groups
// Assumes : AXI4-Lite master, one clock, asynchronous active-high reset
// Notes   : main supply status reads a fixed value; its layout is open
`timescale 1ns/1ps
module ram_section_power_control
	import ram_power_pkg::*;
(
	input  wire  logic                    clk,
	input  wire  logic                    reset,
	input  wire  logic [ADDR_W-1:0]       awaddr,
	input  wire  logic                    awvalid,
	output logic                          awready,
	input  wire  logic [31:0]             wdata,
	input  wire  logic [3:0]              wstrb,
	input  wire  logic                    wvalid,
	output logic                          wready,
	output logic [1:0]                    bresp,
	output logic                          bvalid,
	input  wire  logic                    bready,
	input  wire  logic [ADDR_W-1:0]       araddr,
	input  wire  logic                    arvalid,
	output logic                          arready,
	output logic [31:0]                   rdata,
	output logic [1:0]                    rresp,
	output logic                          rvalid,
	input  wire  logic                    rready,
	output logic [GROUP_COUNT*16-1:0]     sectionOn,
	output logic [GROUP_COUNT*16-1:0]     retentionOn
);
	//--------------------------------------------------
	// address decode
	//--------------------------------------------------
	logic              wrPulse;
	logic [ADDR_W-1:0] wrAddr;
	logic [ADDR_W-1:0] rdAddr;
	logic [31:0]       wrData;
	logic [31:0]       rdValue;
	logic              wrOk;
	logic              rdOk;
	logic [31:0]       power [GROUP_COUNT];
	logic [GROUP_COUNT-1:0] wrCtrl, wrSet, wrClr;

	function automatic access_t decode(input logic [ADDR_W-1:0] a, output int grp);
		access_t kind;
		kind = ACC_NONE;
		grp  = 0;
		for (int g = 0; g < GROUP_COUNT; g++) begin
			if (a == CTRL_BASE + GROUP_STRIDE * 12'(g)) begin
				kind = ACC_CTRL;
				grp  = g;
			end
			if (a == SET_BASE + GROUP_STRIDE * 12'(g)) begin
				kind = ACC_SET;
				grp  = g;
			end
			if (a == CLR_BASE + GROUP_STRIDE * 12'(g)) begin
				kind = ACC_CLR;
				grp  = g;
			end
		end
		return kind;
	endfunction : decode

	always_comb begin
		int      wg;
		access_t wk;
		wg = 0;
		wk = decode(wrAddr, wg);
		wrOk = (wk != ACC_NONE);
		for (int g = 0; g < GROUP_COUNT; g++) begin
			wrCtrl[g] = wrPulse && wk == ACC_CTRL && wg == g;
			wrSet[g]  = wrPulse && wk == ACC_SET && wg == g;
			wrClr[g]  = wrPulse && wk == ACC_CLR && wg == g;
		end
	end

	// every group view returns the control word; reads never write state
	always_comb begin
		int      rg;
		access_t rk;
		rg = 0;
		rk = decode(rdAddr, rg);
		rdOk    = 1'b1;
		rdValue = 32'h00000000;
		if (rk != ACC_NONE) begin
			rdValue = power[rg];
		end else if (rdAddr == SUPPLY_STAT_OFF) begin
			rdValue = SUPPLY_STAT_VALUE;
		end else begin
			rdOk = 1'b0;
		end
	end

	//--------------------------------------------------
	// bus and groups
	//--------------------------------------------------
	axil_slave u_bus (
		.clk     (clk),
		.reset   (reset),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wrPulse (wrPulse),
		.wrAddr  (wrAddr),
		.wrData  (wrData),
		.wrOk    (wrOk),
		.rdAddr  (rdAddr),
		.rdValue (rdValue),
		.rdOk    (rdOk)
	);

	for (genvar g = 0; g < GROUP_COUNT; g++) begin : gen_grp
		ram_power_group u_grp (
			.clk    (clk),
			.reset  (reset),
			.wrCtrl (wrCtrl[g]),
			.wrSet  (wrSet[g]),
			.wrClr  (wrClr[g]),
			.wrData (wrData),
			.power  (power[g])
		);
		assign sectionOn[16*g +: 16]   = power[g][SECTION_LSB +: 16];
		assign retentionOn[16*g +: 16] = power[g][RETENTION_LSB +: 16];
	end

	AST_RESET_VALUE: assert property (@(posedge clk)
		$fell(reset) |-> (power[0] == POWER_RESET && power[8] == POWER_RESET))
		else $error("group not at reset value");
	AST_ONE_GROUP: assert property (@(posedge clk) disable iff (reset)
		$onehot0(wrCtrl | wrSet | wrClr))
		else $error("write reached more than one group");
	AST_READ_MIRROR: assert property (@(posedge clk) disable iff (reset)
		(arvalid && arready && araddr == SET_BASE) |=> (rdata == $past(power[0])))
		else $error("set view did not read control word");
endmodule : ram_section_power_control

// ===== sim/test_ram_section_power_control.sv
// Purpose : self-checking bench for the RAM section power register bank
// Assumes : bready and rready held high after reset, one access at a time
// Notes   : a monitor checks every bus response against queued expectations
`timescale 1ns/1ps
module test_ram_section_power_control;
	import ram_power_pkg::*;
	logic                      clk, reset, awvalid, wvalid, bready, arvalid, rready;
	logic                      awready, wready, bvalid, arready, rvalid;
	logic [ADDR_W-1:0]         awaddr, araddr;
	logic [31:0]               wdata, rdata, lf;
	logic [3:0]                wstrb;
	logic [1:0]                bresp, rresp;
	logic [GROUP_COUNT*16-1:0] sectionOn, retentionOn;
	logic [31:0]               pw [GROUP_COUNT];
	logic [31:0]               rqD [$];
	logic [1:0]                rqR [$];
	logic [1:0]                wqR [$];
	int                        miscompares, n_checks;

	ram_section_power_control u_ram_section_power_control (.clk, .reset, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sectionOn, .retentionOn);

	always #25 clk = ~clk;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [31:0] msk(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : msk

	function automatic logic [11:0] adr(input logic [11:0] b, input int g);
		return b + GROUP_STRIDE * 12'(g);
	endfunction : adr

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic ports();
		for (int g = 0; g < GROUP_COUNT; g++) begin
			chk({16'h0, sectionOn[16*g +: 16]}, {16'h0, pw[g][15:0]});
			chk({16'h0, retentionOn[16*g +: 16]}, {16'h0, pw[g][31:16]});
		end
	endtask : ports

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// ---------------------------------------------------------------
	// bus master
	// ---------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] e);
		bit aw, w;
		int n;
		aw = 0;
		w = 0;
		n = 0;
		wqR.push_back(e);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w) && n < 50) begin
			@(posedge clk);
			n++;
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge clk);
			n++;
		end while (bvalid !== 1'b1 && n < 60);
		if (n >= 60) begin
			miscompares++;
			$display("[ERR] t=%0t write response timed out", $time);
		end
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		rqD.push_back(d);
		rqR.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (rvalid !== 1'b1 && n < 60);
		if (n >= 60) begin
			miscompares++;
			$display("[ERR] t=%0t read response timed out", $time);
		end
	endtask : rd

	// ---------------------------------------------------------------
	// response monitor
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			chk(rdata, rqD.pop_front());
			chk({30'h0, rresp}, {30'h0, rqR.pop_front()});
		end
		if (bvalid === 1'b1 && bready === 1'b1)
			chk({30'h0, bresp}, {30'h0, wqR.pop_front()});
	end

	// hang guard, well beyond the few hundred cycles the sequence needs
	initial begin
		#2000000;
		miscompares++;
		$display("[ERR] t=%0t watchdog expired", $time);
		conclude();
	end

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 0;
		reset = 1;
		{awvalid, wvalid, arvalid, bready, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		miscompares = 0;
		n_checks = 0;
		lf = 32'hb786;
		for (int g = 0; g < GROUP_COUNT; g++)
			pw[g] = POWER_RESET;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		bready <= 1'b1;
		rready <= 1'b1;
		@(posedge clk);
		ports();
		for (int g = 0; g < GROUP_COUNT; g++)
			for (int k = 0; k < 3; k++)
				rd(adr(CTRL_BASE, g) + 12'(4 * k), POWER_RESET, RESP_OKAY);
		for (int g = 0; g < GROUP_COUNT; g++) begin
			lf = (g == 4) ? 32'hffffffff : lfsr(lf);
			wr(adr(SET_BASE, g), lf, 4'hf, RESP_OKAY);
			pw[g] = pw[g] | lf;
			rd(adr(CLR_BASE, g), pw[g], RESP_OKAY);
			lf = (g == 4) ? 32'hffffffff : lfsr(lf);
			wr(adr(CLR_BASE, g), lf, (g == 4) ? 4'hf : lf[7:4], RESP_OKAY);
			pw[g] = pw[g] & ~(lf & msk((g == 4) ? 4'hf : lf[7:4]));
			rd(adr(SET_BASE, g), pw[g], RESP_OKAY);
			rd(adr(CTRL_BASE, g), pw[g], RESP_OKAY);
		end
		ports();
		wr(adr(CTRL_BASE, 8), 32'ha5a55a5a, 4'hf, RESP_OKAY);
		pw[8] = 32'ha5a55a5a;
		rd(adr(CTRL_BASE, 8), pw[8], RESP_OKAY);
		rd(12'h90c, 32'h0, RESP_SLVERR);
		rd(adr(CTRL_BASE, 9), 32'h0, RESP_SLVERR);
		wr(adr(SET_BASE, 9), 32'hffffffff, 4'hf, RESP_SLVERR);
		rd(SUPPLY_STAT_OFF, SUPPLY_STAT_VALUE, RESP_OKAY);
		ports();
		// reset in mid-run must restore every group at once
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		for (int g = 0; g < GROUP_COUNT; g++)
			pw[g] = POWER_RESET;
		ports();
		reset <= 1'b0;
		@(posedge clk);
		rd(adr(SET_BASE, 3), POWER_RESET, RESP_OKAY);
		repeat (4) @(posedge clk);
		conclude();
	end
endmodule : test_ram_section_power_control
